// ---- core/emb_bus.sv ----
/*
 * external memory bus, strobes and port pins of an 8-bit controller.
 * assumes the core holds port latches and requests on clk_i.
 */
// Overview of operation
// R01: low address and data share first port
// R02: bus mode drives ones strongly on first port
// R03: plain first port is open drain
// R04: upper port carries high address, strong ones
// R05: short pointer access keeps upper latch
// R06: address latch strobe at one sixth rate
// R07: data access skips one latch strobe
// R08: fetch strobe twice per machine cycle
// R09: data access suppresses two fetch strobes
// R10: no fetch strobe for internal code
// R11: select high: internal up to 3FFF
// R12: select low: all code external
// R13: data write and read strobes on port three
// R14: reset pin held two machine cycles
// R15: reset forces ports one to three high
// R16: ports one to three use weak pullups
// R17: port one carries third timer inputs
// R18: port three carries serial, interrupt, timer pins
// R19: power down stops bus timing
// R20: latch captures address on strobe fall
`timescale 1ns/1ps
`default_nettype none

`include "emb_defs.svh"

module emb_bus (
	input  wire logic        clk_i,                    // clock
	input  wire logic        rst_i,                    // sync reset
	input  wire logic        rst_pin_i,                // reset pin
	input  wire logic        external_code_select_i,   // code select pin
	input  wire logic        power_down_i,             // power down
	input  wire logic [15:0] fetch_addr_i,             // code address
	output logic      [7:0]  fetch_data_o,             // code byte
	output logic             fetch_valid_o,            // code byte pulse
	input  wire logic        xmem_req_i,               // data access request
	input  wire logic        xmem_wr_i,                // write access
	input  wire logic        xmem_wide_i,              // 16-bit pointer
	input  wire logic [15:0] xmem_addr_i,              // data address
	input  wire logic [7:0]  xmem_wdata_i,             // write data
	output logic      [7:0]  xmem_rdata_o,             // read data
	output logic             xmem_done_o,              // access end pulse
	input  wire logic [7:0]  p0_latch_i,               // port 0 latch
	input  wire logic [7:0]  p1_latch_i,               // port 1 latch
	input  wire logic [7:0]  upper_port_latch_i,       // port 2 latch
	input  wire logic [7:0]  p3_latch_i,               // port 3 latch
	input  wire logic [7:0]  p0_pin_i,                 // port 0 pins in
	input  wire logic [7:0]  p1_pin_i,                 // port 1 pins in
	input  wire logic [7:0]  p2_pin_i,                 // port 2 pins in
	input  wire logic [7:0]  p3_pin_i,                 // port 3 pins in
	output logic      [7:0]  p0_pin_o,                 // port 0 out
	output logic      [7:0]  p0_oe_o,                  // port 0 enable
	output logic      [7:0]  p1_pin_o,                 // port 1 out
	output logic      [7:0]  p1_oe_o,                  // port 1 enable
	output logic      [7:0]  p1_pullup_o,              // port 1 pullup
	output logic      [7:0]  p2_pin_o,                 // port 2 out
	output logic      [7:0]  p2_oe_o,                  // port 2 enable
	output logic      [7:0]  p2_pullup_o,              // port 2 pullup
	output logic      [7:0]  p3_pin_o,                 // port 3 out
	output logic      [7:0]  p3_oe_o,                  // port 3 enable
	output logic      [7:0]  p3_pullup_o,              // port 3 pullup
	output logic [7:0]       p_in_0_o,                 // port 0 read
	output logic [7:0]       p_in_1_o,                 // port 1 read
	output logic [7:0]       p_in_2_o,                 // port 2 read
	output logic [7:0]       p_in_3_o,                 // port 3 read
	output logic             address_latch_strobe_o,   // latch strobe
	output logic             program_fetch_strobe_n_o, // fetch strobe
	input  wire logic        serial_tx_i,              // serial out
	output logic             serial_rx_o,              // serial in
	output logic             ext_interrupt_0_o,        // interrupt 0
	output logic             ext_interrupt_1_o,        // interrupt 1
	output logic             timer0_count_in_o,        // timer 0 count
	output logic             timer1_count_in_o,        // timer 1 count
	output logic             timer2_clock_in_o,        // timer 2 clock
	output logic             timer2_trigger_in_o,      // timer 2 trigger
	output logic             device_reset_o            // internal reset
);
	// ==========================================================
	// pin synchronisers
	logic [`EMB_SYNC_W-1:0] sync_q;
	logic                   rst_pin_s;
	logic                   ea_s;

	emb_sync #(.W(`EMB_SYNC_W)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({rst_pin_i, external_code_select_i, p3_pin_i,
		         p2_pin_i, p1_pin_i, p0_pin_i}),
		.q_o   (sync_q)
	);

	assign p_in_0_o  = sync_q[7:0];
	assign p_in_1_o  = sync_q[15:8];
	assign p_in_2_o  = sync_q[23:16];
	assign p_in_3_o  = sync_q[31:24];
	assign ea_s      = sync_q[32];
	assign rst_pin_s = sync_q[33];

	assign timer2_clock_in_o   = p_in_1_o[`EMB_P1_T2];   // [R17]
	assign timer2_trigger_in_o = p_in_1_o[`EMB_P1_TIMER2_TRIGGER_IN]; // [R17]
	assign serial_rx_o         = p_in_3_o[`EMB_P3_RX];   // [R18]
	assign ext_interrupt_0_o   = p_in_3_o[`EMB_P3_EXT_INTERRUPT_0]; // [R18]
	assign ext_interrupt_1_o   = p_in_3_o[`EMB_P3_EXT_INTERRUPT_1]; // [R18]
	assign timer0_count_in_o   = p_in_3_o[`EMB_P3_T0];   // [R18]
	assign timer1_count_in_o   = p_in_3_o[`EMB_P3_T1];   // [R18]

	// ==========================================================
	// reset qualification
	logic [4:0] rst_cnt, next_rst_cnt;
	logic       dev_rst, next_dev_rst;

	// pin must be seen high for two machine cycles
	always_comb begin
		if (!rst_pin_s)
			next_rst_cnt = 5'h00;
		else if (rst_cnt == `EMB_RST_CYCLES)
			next_rst_cnt = rst_cnt;
		else
			next_rst_cnt = rst_cnt + 5'h01;
		next_dev_rst = rst_pin_s && (next_rst_cnt == `EMB_RST_CYCLES); // [R14]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_cnt <= 5'h00;
			dev_rst <= 1'b0;
		end else begin
			rst_cnt <= next_rst_cnt;
			dev_rst <= next_dev_rst;
		end
	end

	assign device_reset_o = dev_rst;

	// ==========================================================
	// machine cycle sequencer
	logic [3:0]            phase, next_phase;
	emb_pkg::emb_cycle_type cyc, next_cyc;
	logic                  ale, next_ale;
	logic                  program_fetch_strobe_n, next_program_fetch_strobe_n;
	logic                  rd_n, next_rd_n;
	logic                  wr_n, next_wr_n;
	logic                  ext_slot, next_ext_slot;
	logic [15:0]           code_addr, next_code_addr;
	logic                  x_wr, next_x_wr;
	logic                  x_wide, next_x_wide;
	logic [15:0]           x_addr, next_x_addr;
	logic [7:0]            x_wdata, next_x_wdata;
	logic                  p0_bus, next_p0_bus;
	logic [7:0]            p0_out, next_p0_out;
	logic [7:0]            p0_oe, next_p0_oe;
	logic                  p2_bus, next_p2_bus;
	logic [7:0]            p2_out, next_p2_out;
	logic [7:0]            fdata, next_fdata;
	logic                  fvalid, next_fvalid;
	logic [7:0]            rdata, next_rdata;
	logic                  done, next_done;
	logic [1:0]            fpend, next_fpend;
	logic [3:0]            np, noff, coff;

	always_comb begin
		np   = (phase == `EMB_PHASE_LAST) ? 4'h0 : phase + 4'h1;
		noff = (np >= `EMB_HALF) ? np - `EMB_HALF : np;
		coff = (phase >= `EMB_HALF) ? phase - `EMB_HALF : phase;
		next_phase     = phase;
		next_cyc       = cyc;
		next_ale       = 1'b0;
		next_program_fetch_strobe_n    = 1'b1;
		next_rd_n      = 1'b1;
		next_wr_n      = 1'b1;
		next_ext_slot  = ext_slot;
		next_code_addr = code_addr;
		next_x_wr      = x_wr;
		next_x_wide    = x_wide;
		next_x_addr    = x_addr;
		next_x_wdata   = x_wdata;
		next_p0_bus    = 1'b0;
		next_p0_out    = p0_out;
		next_p0_oe     = `EMB_ZERO8;
		next_p2_bus    = 1'b0;
		next_p2_out    = p2_out;
		next_fdata     = fdata;
		next_fvalid    = 1'b0;
		next_rdata     = rdata;
		next_done      = 1'b0;
		next_fpend     = {fpend[0], 1'b0};
		if (dev_rst) begin
			// parked on the last phase so the first slot opens with a full strobe
			next_phase    = `EMB_PHASE_LAST;
			next_cyc      = emb_pkg::EMB_CYC_FETCH;
			next_ext_slot = 1'b0;
		end else if (power_down_i) begin
			// clock stopped: sequencer frozen, both strobes low
			next_program_fetch_strobe_n = 1'b0; // [R19]
		end else begin
			next_phase = np;
			// data access starts only on a machine cycle boundary
			if (phase == `EMB_PHASE_LAST) begin
				if (cyc == emb_pkg::EMB_CYC_FETCH && xmem_req_i && !done) begin
					next_cyc     = emb_pkg::EMB_CYC_DATA;
					next_x_wr    = xmem_wr_i;
					next_x_wide  = xmem_wide_i;
					next_x_addr  = xmem_addr_i;
					next_x_wdata = xmem_wdata_i;
				end else begin
					next_cyc = emb_pkg::EMB_CYC_FETCH;
				end
			end
			if (next_cyc == emb_pkg::EMB_CYC_FETCH) begin
				if (noff == 4'h0) begin
					next_code_addr = fetch_addr_i;
					next_ext_slot  = !ea_s                             // [R12]
						|| (fetch_addr_i > `EMB_CODE_INT_TOP);        // [R11]
				end
				next_ale = (noff < `EMB_ALE_LEN);                      // [R06]
				if (next_ext_slot) begin
					next_p0_bus = 1'b1;
					next_p0_out = next_code_addr[7:0];                 // [R01]
					// address held one phase past the strobe fall
					next_p0_oe  = (noff < `EMB_ADDR_LEN) ? `EMB_ONES8
						: `EMB_ZERO8;                                  // [R02] [R20]
					next_p2_bus = 1'b1;                                // [R04]
					next_p2_out = next_code_addr[15:8];
					next_program_fetch_strobe_n = !(noff >= `EMB_PROGRAM_FETCH_STROBE_FIRST);          // [R08]
				end else begin
					next_program_fetch_strobe_n = 1'b1;                                // [R10]
				end
			end else begin
				next_ext_slot = 1'b0;
				next_program_fetch_strobe_n   = 1'b1;                                  // [R09]
				next_ale      = (np < `EMB_ALE_LEN);                   // [R07]
				next_p0_bus   = 1'b1;
				if (np < `EMB_XSTB_FIRST) begin
					next_p0_out = next_x_addr[7:0];                    // [R01]
					next_p0_oe  = `EMB_ONES8;                          // [R02]
				end else begin
					next_p0_out = next_x_wdata;
					next_p0_oe  = next_x_wr ? `EMB_ONES8 : `EMB_ZERO8;
				end
				next_p2_bus = next_x_wide;                             // [R04] [R05]
				next_p2_out = next_x_addr[15:8];
				if (np >= `EMB_XSTB_FIRST && np <= `EMB_XSTB_LAST) begin
					next_wr_n = !next_x_wr;                            // [R13]
					next_rd_n = next_x_wr;                             // [R13]
				end
			end
			// code byte reaches the synchronised pins two clocks after the strobe
			next_fpend[0] = (cyc == emb_pkg::EMB_CYC_FETCH && ext_slot
				&& coff == `EMB_PROGRAM_FETCH_STROBE_LAST);
			if (fpend[1]) begin
				next_fdata  = p_in_0_o;
				next_fvalid = 1'b1;
			end
			if (cyc == emb_pkg::EMB_CYC_DATA && !x_wr
				&& phase == `EMB_XSTB_LAST)
				next_rdata = p_in_0_o;
			if (cyc == emb_pkg::EMB_CYC_DATA && phase == `EMB_PHASE_LAST)
				next_done = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase     <= `EMB_PHASE_LAST;
			cyc       <= emb_pkg::EMB_CYC_FETCH;
			ale       <= 1'b0;
			program_fetch_strobe_n    <= 1'b1;
			rd_n      <= 1'b1;
			wr_n      <= 1'b1;
			ext_slot  <= 1'b0;
			code_addr <= 16'h0000;
			x_wr      <= 1'b0;
			x_wide    <= 1'b0;
			x_addr    <= 16'h0000;
			x_wdata   <= 8'h00;
			p0_bus    <= 1'b0;
			p0_out    <= 8'h00;
			p0_oe     <= 8'h00;
			p2_bus    <= 1'b0;
			p2_out    <= 8'h00;
			fdata     <= 8'h00;
			fvalid    <= 1'b0;
			rdata     <= 8'h00;
			done      <= 1'b0;
			fpend     <= 2'h0;
		end else begin
			phase     <= next_phase;
			cyc       <= next_cyc;
			ale       <= next_ale;
			program_fetch_strobe_n    <= next_program_fetch_strobe_n;
			rd_n      <= next_rd_n;
			wr_n      <= next_wr_n;
			ext_slot  <= next_ext_slot;
			code_addr <= next_code_addr;
			x_wr      <= next_x_wr;
			x_wide    <= next_x_wide;
			x_addr    <= next_x_addr;
			x_wdata   <= next_x_wdata;
			p0_bus    <= next_p0_bus;
			p0_out    <= next_p0_out;
			p0_oe     <= next_p0_oe;
			p2_bus    <= next_p2_bus;
			p2_out    <= next_p2_out;
			fdata     <= next_fdata;
			fvalid    <= next_fvalid;
			rdata     <= next_rdata;
			done      <= next_done;
			fpend     <= next_fpend;
		end
	end

	assign address_latch_strobe_o   = ale;
	assign program_fetch_strobe_n_o = program_fetch_strobe_n;
	assign fetch_data_o             = fdata;
	assign fetch_valid_o            = fvalid;
	assign xmem_rdata_o             = rdata;
	assign xmem_done_o              = done;

	// ==========================================================
	// port pins
	logic [7:0] p3_eff;

	// strobes and serial out ride on the port three latch
	assign p3_eff = p3_latch_i & {rd_n, wr_n, 4'hF, serial_tx_i, 1'b1}; // [R13] [R18]

	emb_port #(.OPEN_DRAIN(1'b1)) u_p0 (
		.force_i  (1'b0),
		.latch_i  (p0_latch_i),                                    // [R03]
		.bus_i    (p0_bus),
		.bdata_i  (p0_out),
		.boe_i    (p0_oe),
		.pin_o    (p0_pin_o),
		.oe_o     (p0_oe_o),
		.pullup_o ()
	);

	emb_port #(.OPEN_DRAIN(1'b0)) u_p1 (
		.force_i  (rst_pin_i),                                     // [R15]
		.latch_i  (p1_latch_i),                                    // [R16]
		.bus_i    (1'b0),
		.bdata_i  (8'h00),
		.boe_i    (8'h00),
		.pin_o    (p1_pin_o),
		.oe_o     (p1_oe_o),
		.pullup_o (p1_pullup_o)
	);

	emb_port #(.OPEN_DRAIN(1'b0)) u_p2 (
		.force_i  (rst_pin_i),                                     // [R15]
		.latch_i  (upper_port_latch_i),                            // [R05] [R16]
		.bus_i    (p2_bus),
		.bdata_i  (p2_out),
		.boe_i    (8'hFF),
		.pin_o    (p2_pin_o),
		.oe_o     (p2_oe_o),
		.pullup_o (p2_pullup_o)
	);

	emb_port #(.OPEN_DRAIN(1'b0)) u_p3 (
		.force_i  (rst_pin_i),                                     // [R15]
		.latch_i  (p3_eff),                                        // [R16]
		.bus_i    (1'b0),
		.bdata_i  (8'h00),
		.boe_i    (8'h00),
		.pin_o    (p3_pin_o),
		.oe_o     (p3_oe_o),
		.pullup_o (p3_pullup_o)
	);

	// ==========================================================
	// checks
	AST_ALE_PERIOD: assert property (@(posedge clk_i) // [R06]
		disable iff (rst_i || power_down_i || dev_rst)
		$rose(ale) |-> ##6 (ale || cyc == emb_pkg::EMB_CYC_DATA))
		else $error("latch strobe period not six clocks");

	AST_ALE_SKIP: assert property (@(posedge clk_i) // [R07]
		disable iff (rst_i)
		(cyc == emb_pkg::EMB_CYC_DATA && phase == `EMB_HALF) |-> !ale[*6])
		else $error("latch strobe not skipped in data access");

	AST_PROGRAM_FETCH_STROBE_TWICE: assert property (@(posedge clk_i) // [R08]
		disable iff (rst_i || power_down_i || dev_rst)
		$fell(program_fetch_strobe_n) |-> !program_fetch_strobe_n[*3] ##1 program_fetch_strobe_n)
		else $error("fetch strobe width wrong");

	AST_PROGRAM_FETCH_STROBE_DATA: assert property (@(posedge clk_i) // [R09]
		disable iff (rst_i || power_down_i)
		(cyc == emb_pkg::EMB_CYC_DATA && !$past(power_down_i)) |-> program_fetch_strobe_n)
		else $error("fetch strobe active in data access");

	AST_PROGRAM_FETCH_STROBE_INT: assert property (@(posedge clk_i) // [R10]
		disable iff (rst_i || power_down_i)
		(!ext_slot && !$past(power_down_i)) |-> program_fetch_strobe_n)
		else $error("fetch strobe active for internal code");

	AST_CODE_SEL: assert property (@(posedge clk_i) // [R11]
		disable iff (rst_i || power_down_i || dev_rst)
		($rose(ale) && cyc == emb_pkg::EMB_CYC_FETCH) |-> ext_slot ==
		(!$past(ea_s) || $past(fetch_addr_i) > `EMB_CODE_INT_TOP))
		else $error("code space select wrong");

	AST_P0_HOLD: assert property (@(posedge clk_i) // [R01]
		disable iff (rst_i || power_down_i)
		($fell(ale) && p0_bus) |-> p0_oe == `EMB_ONES8)
		else $error("low address not held after strobe");

	AST_P2_WIDE: assert property (@(posedge clk_i) // [R04]
		disable iff (rst_i || power_down_i)
		(cyc == emb_pkg::EMB_CYC_DATA && x_wide)
		|-> p2_bus && p2_out == x_addr[15:8])
		else $error("high address missing");

	AST_P2_SHORT: assert property (@(posedge clk_i) // [R05]
		disable iff (rst_i || power_down_i)
		(cyc == emb_pkg::EMB_CYC_DATA && !x_wide) |-> !p2_bus)
		else $error("upper latch replaced in short access");

	AST_WR_STB: assert property (@(posedge clk_i) // [R13]
		disable iff (rst_i)
		!wr_n |-> cyc == emb_pkg::EMB_CYC_DATA && x_wr && p0_oe == `EMB_ONES8)
		else $error("write strobe outside write access");

	AST_RST_FORCE: assert property (@(posedge clk_i) // [R15]
		rst_pin_i |-> (p1_oe_o == `EMB_ZERO8) && (p3_pin_o == `EMB_ONES8))
		else $error("ports not forced high in reset");
endmodule

`default_nettype wire

// ---- core/emb_port.sv ----
/*
 * pin drive for one 8-bit port: plain port or memory bus.
 * assumes a resolver outside that applies pullup_o as a weak pull.
 */
`timescale 1ns/1ps
`default_nettype none

`include "emb_defs.svh"

module emb_port #(
	parameter bit OPEN_DRAIN = 1'b0
) (
	input  wire logic       force_i,  // async reset force to one
	input  wire logic [7:0] latch_i,  // port latch
	input  wire logic       bus_i,    // bus mode
	input  wire logic [7:0] bdata_i,  // bus value
	input  wire logic [7:0] boe_i,    // bus enables
	output logic      [7:0] pin_o,    // pin value
	output logic      [7:0] oe_o,     // pin drive enable
	output logic      [7:0] pullup_o  // weak pullup enable
);
	always_comb begin
		if (force_i) begin
			pin_o    = `EMB_ONES8;
			oe_o     = `EMB_ZERO8;
			pullup_o = `EMB_ONES8;
		end else if (bus_i) begin
			pin_o    = bdata_i;
			oe_o     = boe_i;
			pullup_o = `EMB_ZERO8;
		end else begin
			// only a zero is driven; a one floats or is held weakly
			pin_o    = `EMB_ZERO8;
			oe_o     = ~latch_i;
			pullup_o = OPEN_DRAIN ? `EMB_ZERO8 : latch_i;
		end
	end
endmodule

`default_nettype wire

// ---- core/emb_sync.sv ----
/*
 * three flip-flop input synchroniser with agreement filter.
 * assumes inputs asynchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module emb_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_i,  // clock
	input  wire logic         rst_i,  // sync reset
	input  wire logic [W-1:0] d_i,    // raw pins
	output logic      [W-1:0] q_o     // filtered value
);
	logic [W-1:0] s1, s2, s3, q;
	logic [W-1:0] next_q;

	// a change counts once the second and third stages agree
	always_comb begin
		next_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q  <= '0;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end

	assign q_o = q;
endmodule

`default_nettype wire

// ---- include/emb_defs.svh ----
/*
 * constants for the external memory bus and port pin logic.
 * assumes one 20 MHz clock that stands for the oscillator.
 */
`ifndef EMB_DEFS_SVH
`define EMB_DEFS_SVH

// machine cycle phases (one clock each)
`define EMB_PHASE_LAST   4'hB
`define EMB_HALF         4'h6
`define EMB_ALE_LEN      4'h2
`define EMB_ADDR_LEN     4'h3
`define EMB_PROGRAM_FETCH_STROBE_FIRST   4'h3
`define EMB_PROGRAM_FETCH_STROBE_LAST    4'h5
`define EMB_XSTB_FIRST   4'h3
`define EMB_XSTB_LAST    4'hA
// code space and reset
`define EMB_CODE_INT_TOP 16'h3FFF
`define EMB_RST_CYCLES   5'h18
`define EMB_ONES8        8'hFF
`define EMB_ZERO8        8'h00
// pin positions
`define EMB_P1_T2        0
`define EMB_P1_TIMER2_TRIGGER_IN      1
`define EMB_P3_RX        0
`define EMB_P3_TX        1
`define EMB_P3_EXT_INTERRUPT_0      2
`define EMB_P3_EXT_INTERRUPT_1      3
`define EMB_P3_T0        4
`define EMB_P3_T1        5
`define EMB_P3_WR        6
`define EMB_P3_RD        7
`define EMB_SYNC_W       34

`endif

// ---- include/emb_pkg.sv ----
/*
 * types for the external memory bus block.
 * assumes emb_defs.svh for all numeric constants.
 */
package emb_pkg;
	typedef enum logic [0:0] {
		EMB_CYC_FETCH = 1'b0,
		EMB_CYC_DATA  = 1'b1
	} emb_cycle_type;
endpackage

// ---- verification/emb_bus_tb.sv ----
/*
 * self-checking bench for the memory bus and port pins.
 * assumes emb_bus and emb_xmem_model compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module emb_bus_tb;
	logic clk_i = 1'b0, rst_i = 1'b1, rst_pin_i = 1'b0, external_code_select_i = 1'b1;
	logic power_down_i = 1'b0, xmem_req_i = 1'b0, xmem_wr_i = 1'b0, xmem_wide_i = 1'b0;
	logic serial_tx_i = 1'b1;
	logic [15:0] fetch_addr_i = 16'h3FFF, xmem_addr_i = 16'h0000;
	logic [7:0] xmem_wdata_i = 8'h00, p0_latch_i = 8'hFF, p1_latch_i = 8'hFF;
	logic [7:0] upper_port_latch_i = 8'hFF, p3_latch_i = 8'hFF, p1_ext = 8'hFF;
	logic [7:0] p3_ext = 8'hFF, rdat;
	wire logic [7:0] p0_pin_i, p1_pin_i, p2_pin_i, p3_pin_i;
	logic [7:0] fetch_data_o, xmem_rdata_o, p0_pin_o, p0_oe_o, p1_pin_o, p1_oe_o;
	logic [7:0] p1_pullup_o, p2_pin_o, p2_oe_o, p2_pullup_o, p3_pin_o, p3_oe_o;
	logic [7:0] p3_pullup_o, p_in_0_o, p_in_1_o, p_in_2_o, p_in_3_o;
	logic fetch_valid_o, xmem_done_o, address_latch_strobe_o, program_fetch_strobe_n_o;
	logic serial_rx_o, ext_interrupt_0_o, ext_interrupt_1_o, timer0_count_in_o;
	logic timer1_count_in_o, timer2_clock_in_o, timer2_trigger_in_o, device_reset_o;
	logic ale_q = 1'b0, program_fetch_strobe_q = 1'b1;
	int fail_count = 0, checks_done = 0, ale_n = 0, program_fetch_strobe_n = 0;

	function automatic logic [7:0] qpin(input logic [7:0] ext, pin, oe, pu);
		return ext & ((oe & pin) | (~oe & pu));
	endfunction

	assign p1_pin_i = qpin(p1_ext, p1_pin_o, p1_oe_o, p1_pullup_o);
	assign p2_pin_i = qpin(8'hFF, p2_pin_o, p2_oe_o, p2_pullup_o);
	assign p3_pin_i = qpin(p3_ext, p3_pin_o, p3_oe_o, p3_pullup_o);

	emb_bus emb_bus_i (.clk_i, .rst_i, .rst_pin_i, .external_code_select_i, .power_down_i,
		.fetch_addr_i, .fetch_data_o, .fetch_valid_o, .xmem_req_i, .xmem_wr_i, .xmem_wide_i,
		.xmem_addr_i, .xmem_wdata_i, .xmem_rdata_o, .xmem_done_o, .p0_latch_i, .p1_latch_i,
		.upper_port_latch_i, .p3_latch_i, .p0_pin_i, .p1_pin_i, .p2_pin_i, .p3_pin_i,
		.p0_pin_o, .p0_oe_o, .p1_pin_o, .p1_oe_o, .p1_pullup_o, .p2_pin_o, .p2_oe_o,
		.p2_pullup_o, .p3_pin_o, .p3_oe_o, .p3_pullup_o, .p_in_0_o, .p_in_1_o, .p_in_2_o,
		.p_in_3_o, .address_latch_strobe_o, .program_fetch_strobe_n_o, .serial_tx_i,
		.serial_rx_o, .ext_interrupt_0_o, .ext_interrupt_1_o, .timer0_count_in_o,
		.timer1_count_in_o, .timer2_clock_in_o, .timer2_trigger_in_o, .device_reset_o);

	emb_xmem_model emb_xmem_model_i (.clk_i(clk_i), .ale_i(address_latch_strobe_o),
		.fetch_n_i(program_fetch_strobe_n_o), .wr_n_i(p3_pin_i[6]), .rd_n_i(p3_pin_i[7]),
		.p0_pin_i(p0_pin_o), .p0_oe_i(p0_oe_o), .p2_i(p2_pin_i), .bus_o(p0_pin_i));

	always #25 clk_i = ~clk_i;

	// strobe edge counters
	always @(posedge clk_i) begin
		ale_q <= address_latch_strobe_o;
		program_fetch_strobe_q <= program_fetch_strobe_n_o;
		if (address_latch_strobe_o === 1'b1 && ale_q === 1'b0) ale_n++;
		if (program_fetch_strobe_n_o === 1'b0 && program_fetch_strobe_q === 1'b1) program_fetch_strobe_n++;
	end

	// ==========================================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic count_win(input int ale_e, input int program_fetch_strobe_e);
		ale_n = 0;
		program_fetch_strobe_n = 0;
		tick(48);
		chk(ale_n == ale_e, "latch strobe count");
		chk(program_fetch_strobe_n == program_fetch_strobe_e, "fetch strobe count");
	endtask

	task automatic xfer(input logic wr, wide, input logic [15:0] a, input logic [7:0] d, p2e);
		logic seen;
		logic [1:0] st;
		seen = 1'b0;
		st = 2'b11;
		xmem_wr_i = wr;
		xmem_wide_i = wide;
		xmem_addr_i = a;
		xmem_wdata_i = d;
		xmem_req_i = 1'b1;
		ale_n = 0;
		program_fetch_strobe_n = 0;
		for (int i = 0; i < 48; i++) begin
			tick(1);
			if (p3_pin_i[7:6] !== 2'b11 && !seen) begin
				seen = 1'b1;
				st = p3_pin_i[7:6];
				chk(p2_pin_i === p2e, "upper port in data cycle");
			end
			if (xmem_done_o === 1'b1) begin
				rdat = xmem_rdata_o;
				xmem_req_i = 1'b0;
			end
		end
		chk(xmem_req_i === 1'b0, "no data completion");
		chk(st === (wr ? 2'b10 : 2'b01), "wrong data strobe");
		chk(ale_n == 7, "latch strobe not skipped once");
		chk(program_fetch_strobe_n == 6, "fetch strobes not skipped twice");
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset_pin;
		p1_latch_i = 8'h00;
		upper_port_latch_i = 8'h00;
		p3_latch_i = 8'h00;
		tick(2);
		rst_pin_i = 1'b1;
		#1;
		chk({p1_pin_i, p2_pin_i, p3_pin_i} === {3{8'hFF}}, "ports not forced");
		tick(30);
		chk(device_reset_o === 1'b1, "reset not taken");
		rst_pin_i = 1'b0;
		p1_latch_i = 8'h0F;
		upper_port_latch_i = 8'hFF;
		p3_latch_i = 8'hFF;
		tick(30);
		chk(p1_pin_i === 8'h0F, "quasi port level");
		chk(p_in_1_o === 8'h0F && p_in_2_o === 8'hFF, "port read back");
		p1_latch_i = 8'hFF;
	endtask

	task automatic t_ext_fetch;
		external_code_select_i = 1'b0;
		fetch_addr_i = 16'h5AC3;
		tick(24);
		for (int i = 0; i < 12 && address_latch_strobe_o !== 1'b1; i++) tick(1);
		chk(p0_oe_o === 8'hFF && p0_pin_o === 8'hC3, "low address");
		chk(p2_pin_o === 8'h5A && p2_oe_o === 8'hFF, "high address");
		for (int i = 0; i < 12 && fetch_valid_o !== 1'b1; i++) tick(1);
		chk(fetch_data_o === (8'hC3 ^ 8'h5A ^ 8'hA5), "code byte");
		count_win(8, 8);
	endtask

	task automatic t_alt;
		logic [7:0] p3v [2] = '{8'hD6, 8'hEB};
		logic [7:0] p1v [2] = '{8'hFE, 8'hFD};
		for (int k = 0; k < 2; k++) begin
			p3_ext = p3v[k];
			p1_ext = p1v[k];
			serial_tx_i = k[0];
			tick(8);
			chk({timer1_count_in_o, timer0_count_in_o, ext_interrupt_1_o, ext_interrupt_0_o,
				serial_rx_o} === {p3v[k][5:2], p3v[k][0]}, "port three inputs");
			chk(p3_pin_i[1] === k[0], "serial out");
			chk({timer2_trigger_in_o, timer2_clock_in_o} === p1v[k][1:0], "timer2 pins");
		end
		p3_ext = 8'hFF;
		p1_ext = 8'hFF;
	endtask

	task automatic wrap_up;
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk_i);
		fail_count++;
		wrap_up();
	end

	initial begin
		tick(12);
		rst_i = 1'b0;
		t_reset_pin();
		tick(12);
		count_win(8, 0);
		fetch_addr_i = 16'h4000;
		tick(12);
		count_win(8, 8);
		t_ext_fetch();
		xfer(1'b1, 1'b1, 16'h7E81, 8'h96, 8'h7E);
		upper_port_latch_i = 8'h24;
		xfer(1'b0, 1'b0, 16'h9981, 8'h00, 8'h24);
		chk(rdat === 8'h96, "read back");
		external_code_select_i = 1'b1;
		fetch_addr_i = 16'h0100;
		p0_latch_i = 8'hF0;
		tick(24);
		chk((p0_oe_o & 8'hF0) === 8'h00 && p0_pin_i[3:0] === 4'h0, "open drain");
		chk(p_in_0_o[3:0] === 4'h0, "open drain read");
		t_alt();
		power_down_i = 1'b1;
		tick(4);
		chk({address_latch_strobe_o, program_fetch_strobe_n_o} === 2'b00, "pd strobes");
		count_win(0, 0);
		power_down_i = 1'b0;
		tick(12);
		wrap_up();
	end
endmodule

`default_nettype wire

// ---- verification/emb_xmem_model.sv ----
/*
 * external code and data memory with address latch.
 * assumes the bench resolves port three and port two levels.
 */
`timescale 1ns/1ps
`default_nettype none

module emb_xmem_model (
	input  wire logic       clk_i,     // bench clock
	input  wire logic       ale_i,     // address latch strobe
	input  wire logic       fetch_n_i, // code read strobe
	input  wire logic       wr_n_i,    // data write strobe
	input  wire logic       rd_n_i,    // data read strobe
	input  wire logic [7:0] p0_pin_i,  // device drive value
	input  wire logic [7:0] p0_oe_i,   // device drive enable
	input  wire logic [7:0] p2_i,      // upper port level
	output logic      [7:0] bus_o      // resolved first port
);
	logic [7:0] lo = 8'h00;
	logic [7:0] flt = 8'h55;
	logic [7:0] dout;
	logic [7:0] ram [256];

	// released bus shows a toggling pattern, never the last value
	always @(posedge clk_i) flt <= ~flt;
	always @(negedge ale_i) lo = bus_o;
	always @(posedge wr_n_i) ram[lo] = bus_o;
	assign dout = !fetch_n_i ? (lo ^ p2_i ^ 8'hA5) : ram[lo];
	assign bus_o = (p0_oe_i & p0_pin_i)
		| (~p0_oe_i & ((!fetch_n_i || !rd_n_i) ? dout : flt));
endmodule

`default_nettype wire
